// >>> motion_event_readout.sv
// Function
// - Knock event flag reads 1 after any tap, 0 after reset.
// - Knock one flag set on a single tap, reset 0.
// - Knock two flag set on a double tap, reset 0.
// - Knock sign bit: 0 positive, 1 negative, reset 0.
// - Per-axis X, Y, Z tap bits, reset 0.
// - Bit 7 of knock and orientation sources always reads 0.
// - Orientation change flag set on position change, reset 0.
// - Six limit flags Z high down to X low in bits 5..0.
// - Temperature sample ready flag, reset 0.
// - Gyro sample ready flag, reset 0.
// - Accel sample ready flag, reset 0.
// - Temperature word: low byte lower address, high byte next.
// - Temperature sign-extended to bit 15.
// - Rate X word: low byte, then high byte.
// - Rate Y word: low byte, then high byte.
// - Rate Z low byte at its own address.
// - Rate Z high byte at the following address.
module motion_event_readout
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [motion_regs_pkg::ADR_W-1:0] adr_i,
    input wire logic [motion_regs_pkg::SEL_W-1:0] sel_i,
    input wire logic [motion_regs_pkg::DAT_W-1:0] dat_i,
    output logic [motion_regs_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    // Knock detector
    input wire logic knock_evt_i,
    input wire logic knock_one_i,
    input wire logic knock_two_i,
    input wire logic knock_neg_i,
    input wire logic [motion_regs_pkg::AXIS_W-1:0] knock_axis_i,
    // Orientation detector
    input wire logic orient_evt_i,
    input wire logic [motion_regs_pkg::LIM_W-1:0] orient_lim_i,
    // Sample sources
    input wire logic temp_vld_i,
    input wire logic [motion_regs_pkg::TEMP_RAW_W-1:0] temp_raw_i,
    input wire logic gyro_vld_i,
    input wire logic [motion_regs_pkg::WORD_W-1:0] gyro_x_i,
    input wire logic [motion_regs_pkg::WORD_W-1:0] gyro_y_i,
    input wire logic [motion_regs_pkg::WORD_W-1:0] gyro_z_i,
    input wire logic accel_vld_i,
    // Interrupt
    output logic irq_o
);
    import motion_regs_pkg::*;

    logic ack_q;
    logic [DAT_W-1:0] dat_q;
    logic [DAT_W-1:0] rd_d;
    logic [IDX_W-1:0] idx;
    logic take;
    logic rd_take;
    logic wr_take;
    logic [BYTE_W-2:0] knock_q;
    logic [BYTE_W-2:0] orient_q;
    logic temp_rdy_q;
    logic gyro_rdy_q;
    logic accel_rdy_q;
    logic [WORD_W-1:0] temp_q;
    logic [WORD_W-1:0] gyro_x_q;
    logic [WORD_W-1:0] gyro_y_q;
    logic [WORD_W-1:0] gyro_z_q;
    logic [IRQ_N-1:0] irq_ev;
    logic [IRQ_N-1:0] irq_stat_q;
    logic [IRQ_N-1:0] irq_mask_q;
    logic irq_q;

    // Request decode; a new request is taken only when no ack is out
    assign idx = adr_i[IDX_LSB+IDX_W-1:IDX_LSB];
    assign take = cyc_i && stb_i && !ack_q;
    assign rd_take = take && !we_i;
    assign wr_take = take && we_i && sel_i[0];

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    // Read data mux; unmapped indices read zero
    always_comb begin
        rd_d = '0;
        unique case (idx)
            IDX_KNOCK: rd_d[BYTE_W-1:0] = {1'b0, knock_q};
            IDX_ORIENT: rd_d[BYTE_W-1:0] = {1'b0, orient_q};
            IDX_READY: begin
                rd_d[TEMP_RDY_BIT] = temp_rdy_q;
                rd_d[GYRO_RDY_BIT] = gyro_rdy_q;
                rd_d[ACCEL_RDY_BIT] = accel_rdy_q;
            end
            IDX_TEMP_L: rd_d[BYTE_W-1:0] = temp_q[BYTE_W-1:0];
            IDX_TEMP_H: rd_d[BYTE_W-1:0] = temp_q[WORD_W-1:BYTE_W];
            IDX_RATE_X_L: rd_d[BYTE_W-1:0] = gyro_x_q[BYTE_W-1:0];
            IDX_RATE_X_H: rd_d[BYTE_W-1:0] = gyro_x_q[WORD_W-1:BYTE_W];
            IDX_RATE_Y_L: rd_d[BYTE_W-1:0] = gyro_y_q[BYTE_W-1:0];
            IDX_RATE_Y_H: rd_d[BYTE_W-1:0] = gyro_y_q[WORD_W-1:BYTE_W];
            IDX_RATE_Z_L: rd_d[BYTE_W-1:0] = gyro_z_q[BYTE_W-1:0];
            IDX_RATE_Z_H: rd_d[BYTE_W-1:0] = gyro_z_q[WORD_W-1:BYTE_W];
            IDX_IRQ_STATUS: rd_d[IRQ_N-1:0] = irq_stat_q;
            IDX_IRQ_MASK: rd_d[IRQ_N-1:0] = irq_mask_q;
            default: rd_d = '0;
        endcase
    end

    // Read data is captured with the ack so it stands while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (rd_take) begin
            dat_q <= rd_d;
        end
    end

    // Knock source: a new event overrides a clear-on-read in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            knock_q <= '0;
        end else if (knock_evt_i) begin
            knock_q[KNOCK_EVT_BIT] <= 1'b1;
            knock_q[KNOCK_ONE_BIT] <= knock_one_i;
            knock_q[KNOCK_TWO_BIT] <= knock_two_i;
            knock_q[KNOCK_NEG_BIT] <= knock_neg_i;
            knock_q[AXIS_W-1:0] <= knock_axis_i;
        end else if (rd_take && idx == IDX_KNOCK) begin
            knock_q <= '0;
        end
    end

    // Orientation source, same clear-on-read policy as the knock source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            orient_q <= '0;
        end else if (orient_evt_i) begin
            orient_q[ORIENT_CHG_BIT] <= 1'b1;
            orient_q[LIM_W-1:0] <= orient_lim_i;
        end else if (rd_take && idx == IDX_ORIENT) begin
            orient_q <= '0;
        end
    end

    // Temperature sample and its ready flag load together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            temp_q <= WORD_ZERO;
            temp_rdy_q <= 1'b0;
        end else if (temp_vld_i) begin
            temp_q <= {{(WORD_W-TEMP_RAW_W){temp_raw_i[TEMP_RAW_W-1]}}, temp_raw_i};
            temp_rdy_q <= 1'b1;
        end else if (rd_take && idx == IDX_TEMP_H) begin
            temp_rdy_q <= 1'b0; // High byte read ends the sample
        end
    end

    // Gyro triple loads at once so the three axes stay coherent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gyro_x_q <= WORD_ZERO;
            gyro_y_q <= WORD_ZERO;
            gyro_z_q <= WORD_ZERO;
            gyro_rdy_q <= 1'b0;
        end else if (gyro_vld_i) begin
            gyro_x_q <= gyro_x_i;
            gyro_y_q <= gyro_y_i;
            gyro_z_q <= gyro_z_i;
            gyro_rdy_q <= 1'b1;
        end else if (rd_take && idx == IDX_RATE_Z_H) begin
            gyro_rdy_q <= 1'b0; // Last byte of the set
        end
    end

    // Accel data lives elsewhere, so a status read ends its flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accel_rdy_q <= 1'b0;
        end else if (accel_vld_i) begin
            accel_rdy_q <= 1'b1;
        end else if (rd_take && idx == IDX_READY) begin
            accel_rdy_q <= 1'b0;
        end
    end

    // Interrupt event vector
    assign irq_ev[IRQ_KNOCK] = knock_evt_i;
    assign irq_ev[IRQ_ORIENT] = orient_evt_i;
    assign irq_ev[IRQ_TEMP] = temp_vld_i;
    assign irq_ev[IRQ_GYRO] = gyro_vld_i;
    assign irq_ev[IRQ_ACCEL] = accel_vld_i;

    // Sticky status bits, write one to clear; a set wins over the clear
    for (genvar i = 0; i < IRQ_N; i++) begin : g_irq
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                irq_stat_q[i] <= 1'b0;
            end else if (irq_ev[i]) begin
                irq_stat_q[i] <= 1'b1;
            end else if (wr_take && idx == IDX_IRQ_STATUS && dat_i[i]) begin
                irq_stat_q[i] <= 1'b0;
            end
        end
    end

    // Mask register is the only one loaded by writes; status takes write-one-to-clear, all others ignore writes
    // writes ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= '0;
        end else if (wr_take && idx == IDX_IRQ_MASK) begin
            irq_mask_q <= dat_i[IRQ_N-1:0];
        end
    end

    // Registered level; lags the status by one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign irq_o = irq_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_knock_flag: assert property (knock_evt_i |=> knock_q[KNOCK_EVT_BIT])
        else $error("knock event flag not set");
    a_knock_single: assert property (
        knock_evt_i |=> knock_q[KNOCK_ONE_BIT] == $past(knock_one_i))
        else $error("single tap flag wrong");
    a_knock_double: assert property (
        knock_evt_i |=> knock_q[KNOCK_TWO_BIT] == $past(knock_two_i))
        else $error("double tap flag wrong");
    a_knock_sign: assert property (
        knock_evt_i |=> knock_q[KNOCK_NEG_BIT] == $past(knock_neg_i))
        else $error("tap sign wrong");
    a_knock_axes: assert property (
        knock_evt_i ##1 !knock_evt_i && !rd_take |=> knock_q[AXIS_W-1:0] == $past(knock_axis_i, 2))
        else $error("tap axes wrong");
    a_source_msb: assert property (
        rd_take && (idx == IDX_KNOCK || idx == IDX_ORIENT) |=> ack_o && !dat_o[BYTE_W-1])
        else $error("source bit 7 not zero");
    a_orient_change: assert property (
        orient_evt_i |=> orient_q[ORIENT_CHG_BIT])
        else $error("orientation change flag not set");
    a_orient_limits: assert property (
        orient_evt_i |=> orient_q[LIM_W-1:0] == $past(orient_lim_i))
        else $error("orientation limits wrong");
    a_temp_ready: assert property (
        temp_vld_i |=> temp_rdy_q)
        else $error("temperature ready not set");
    a_gyro_ready: assert property (
        gyro_vld_i |=> gyro_rdy_q)
        else $error("gyro ready not set");
    a_accel_ready: assert property (
        accel_vld_i |=> accel_rdy_q)
        else $error("accel ready not set");
    a_temp_high: assert property (
        rd_take && idx == IDX_TEMP_H |=> dat_o[BYTE_W-1:0] == $past(temp_q[WORD_W-1:BYTE_W]))
        else $error("temperature high byte wrong");
    a_temp_sign: assert property (
        temp_vld_i |=> $signed(temp_q) == $signed($past(temp_raw_i)))
        else $error("temperature not sign-extended");
    a_rate_x_high: assert property (
        rd_take && idx == IDX_RATE_X_H |=> dat_o[BYTE_W-1:0] == $past(gyro_x_q[WORD_W-1:BYTE_W]))
        else $error("rate X high byte wrong");
    a_rate_y_low: assert property (
        rd_take && idx == IDX_RATE_Y_L |=> dat_o == {24'h000000, $past(gyro_y_q[BYTE_W-1:0])})
        else $error("rate Y low byte wrong");
    a_rate_z_low: assert property (
        rd_take && idx == IDX_RATE_Z_L |=> dat_o[BYTE_W-1:0] == $past(gyro_z_q[BYTE_W-1:0]))
        else $error("rate Z low byte wrong");
    a_rate_z_high: assert property (
        rd_take && idx == IDX_RATE_Z_H |=> dat_o[BYTE_W-1:0] == $past(gyro_z_q[WORD_W-1:BYTE_W]))
        else $error("rate Z high byte wrong");
    a_sample_coherent: assert property (
        $rose(gyro_rdy_q) |-> gyro_x_q == $past(gyro_x_i) && gyro_y_q == $past(gyro_y_i)
        && gyro_z_q == $past(gyro_z_i))
        else $error("ready flag without fresh sample");
    a_write_ignored: assert property (
        take && we_i && !gyro_vld_i && !temp_vld_i
        |=> $stable(gyro_x_q) && $stable(temp_q) && $stable(gyro_z_q))
        else $error("write changed read-only data");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (take |=> ack_o)
        else $error("request not acknowledged");
    a_ack_request: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    a_upper_zero: assert property (ack_o |-> dat_o[DAT_W-1:BYTE_W] == '0)
        else $error("read data upper bits not zero");
    a_dat_hold: assert property (!rd_take |=> $stable(dat_o))
        else $error("read data changed without a read");

    // Clear points; an event in the same cycle keeps the flag set
    a_knock_clear: assert property (
        rd_take && idx == IDX_KNOCK && !knock_evt_i |=> knock_q == '0)
        else $error("knock source not cleared by read");
    a_orient_clear: assert property (
        rd_take && idx == IDX_ORIENT && !orient_evt_i |=> orient_q == '0)
        else $error("orientation source not cleared by read");
    a_temp_clear: assert property (
        rd_take && idx == IDX_TEMP_H && !temp_vld_i |=> !temp_rdy_q)
        else $error("temperature ready not cleared");
    a_gyro_clear: assert property (
        rd_take && idx == IDX_RATE_Z_H && !gyro_vld_i |=> !gyro_rdy_q)
        else $error("gyro ready not cleared");
    a_accel_clear: assert property (
        rd_take && idx == IDX_READY && !accel_vld_i |=> !accel_rdy_q)
        else $error("accel ready not cleared");

    // Sources hold between their events and clears
    a_knock_hold: assert property (
        !knock_evt_i && !(rd_take && idx == IDX_KNOCK) |=> $stable(knock_q))
        else $error("knock source changed on its own");
    a_orient_hold: assert property (
        !orient_evt_i && !(rd_take && idx == IDX_ORIENT) |=> $stable(orient_q))
        else $error("orientation source changed on its own");
    a_gyro_hold: assert property (!gyro_vld_i |=> $stable(gyro_x_q) && $stable(gyro_y_q))
        else $error("rate sample changed without new data");

    // Interrupt status, mask and level
    a_irq_set: assert property (
        irq_ev != '0 |=> (irq_stat_q & $past(irq_ev)) == $past(irq_ev))
        else $error("interrupt status not set by event");
    a_irq_clear: assert property (
        wr_take && idx == IDX_IRQ_STATUS
        |=> (irq_stat_q & $past(dat_i[IRQ_N-1:0] & ~irq_ev)) == '0)
        else $error("interrupt status not cleared by write");
    a_mask_write: assert property (
        wr_take && idx == IDX_IRQ_MASK |=> irq_mask_q == $past(dat_i[IRQ_N-1:0]))
        else $error("interrupt mask not written");
    a_irq_level: assert property (irq_o |-> $past(irq_stat_q & irq_mask_q) != '0)
        else $error("interrupt raised with no unmasked status");

    c_knock_read: cover property (knock_evt_i ##[1:20] rd_take && idx == IDX_KNOCK);
    c_gyro_read: cover property (gyro_vld_i ##[1:40] rd_take && idx == IDX_RATE_Z_H);
    c_irq_rise: cover property ($rose(irq_o));
    c_set_clear_clash: cover property (temp_vld_i && rd_take && idx == IDX_TEMP_H);
    c_sel_blocked: cover property (take && we_i && !sel_i[0]);
endmodule : motion_event_readout

// >>> motion_host_model.sv
module motion_host_model
    import motion_regs_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Wishbone classic master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [motion_regs_pkg::ADR_W-1:0] adr_o,
    output logic [motion_regs_pkg::SEL_W-1:0] sel_o,
    output logic [motion_regs_pkg::DAT_W-1:0] dat_o,
    input wire logic [motion_regs_pkg::DAT_W-1:0] dat_i,
    input wire logic ack_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = '0;
        sel_o = '0;
        dat_o = '0;
    end

    // One classic cycle; no latency assumed, the bench watchdog ends a hang
    // whole byte returned
    task automatic cycle(input logic wr, input logic [7:0] idx, input logic [7:0] wdat,
                         input logic [3:0] sel, output logic [7:0] rdat);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= wr;
        adr_o <= {idx, 2'b00};
        sel_o <= sel;
        dat_o <= {24'h000000, wdat};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rdat = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask : cycle
endmodule : motion_host_model

// >>> motion_regs_pkg.sv
package motion_regs_pkg;
    // Wishbone geometry: one 32-bit word per register
    localparam int ADR_W = 10;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 8;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_KNOCK = 8'h1c;
    localparam logic [7:0] IDX_ORIENT = 8'h1d;
    localparam logic [7:0] IDX_READY = 8'h1e;
    localparam logic [7:0] IDX_TEMP_L = 8'h20;
    localparam logic [7:0] IDX_TEMP_H = 8'h21;
    localparam logic [7:0] IDX_RATE_X_L = 8'h22;
    localparam logic [7:0] IDX_RATE_X_H = 8'h23;
    localparam logic [7:0] IDX_RATE_Y_L = 8'h24;
    localparam logic [7:0] IDX_RATE_Y_H = 8'h25;
    localparam logic [7:0] IDX_RATE_Z_L = 8'h26;
    localparam logic [7:0] IDX_RATE_Z_H = 8'h27;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
    // Knock source fields
    localparam int KNOCK_EVT_BIT = 6;
    localparam int KNOCK_ONE_BIT = 5;
    localparam int KNOCK_TWO_BIT = 4;
    localparam int KNOCK_NEG_BIT = 3;
    // Orientation source fields; limits occupy bits 5..0
    localparam int ORIENT_CHG_BIT = 6;
    localparam int LIM_W = 6;
    localparam int AXIS_W = 3;
    // Sample-ready fields
    localparam int TEMP_RDY_BIT = 2;
    localparam int GYRO_RDY_BIT = 1;
    localparam int ACCEL_RDY_BIT = 0;
    // Interrupt sources, one bit each
    localparam int IRQ_KNOCK = 0;
    localparam int IRQ_ORIENT = 1;
    localparam int IRQ_TEMP = 2;
    localparam int IRQ_GYRO = 3;
    localparam int IRQ_ACCEL = 4;
    localparam int IRQ_N = 5;
    // Raw temperature converter width, sign-extended to a word
    localparam int TEMP_RAW_W = 12;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage : motion_regs_pkg

// >>> testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import motion_regs_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, irq_o;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] wdat, rdat;
    logic knock_evt_i = 1'b0, orient_evt_i = 1'b0;
    logic temp_vld_i = 1'b0, gyro_vld_i = 1'b0, accel_vld_i = 1'b0;
    logic [5:0] knock_f = '0;
    logic [LIM_W-1:0] orient_lim_i = '0;
    logic [TEMP_RAW_W-1:0] temp_raw_i = '0;
    logic [WORD_W-1:0] gx = '0, gy = '0, gz = '0;
    int num_errors = 0;
    int num_checks = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    motion_host_model motion_host_model_i (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

    motion_event_readout motion_event_readout_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .knock_evt_i(knock_evt_i), .knock_one_i(knock_f[5]),
        .knock_two_i(knock_f[4]), .knock_neg_i(knock_f[3]),
        .knock_axis_i(knock_f[2:0]), .orient_evt_i(orient_evt_i),
        .orient_lim_i(orient_lim_i), .temp_vld_i(temp_vld_i), .temp_raw_i(temp_raw_i),
        .gyro_vld_i(gyro_vld_i), .gyro_x_i(gx), .gyro_y_i(gy), .gyro_z_i(gz),
        .accel_vld_i(accel_vld_i), .irq_o(irq_o));

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        motion_host_model_i.cycle(1'b0, idx, 8'h00, 4'hf, v);
        chk(v, exp);
    endtask : rd_chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] v;
        motion_host_model_i.cycle(1'b1, idx, d, 4'hf, v);
    endtask : wr

    // One-cycle pulse on {accel, gyro, temp, orient, knock}
    task automatic ev(input logic [4:0] s);
        @(posedge clk_i);
        {accel_vld_i, gyro_vld_i, temp_vld_i, orient_evt_i, knock_evt_i} <= s;
        @(posedge clk_i);
        {accel_vld_i, gyro_vld_i, temp_vld_i, orient_evt_i, knock_evt_i} <= 5'h00;
    endtask : ev

    task automatic t_reset();
        for (int i = 8'h1c; i <= 8'h27; i++) begin
            if (i != 8'h1f) rd_chk(8'(i), 8'h00);
        end
        $display("reset values done");
    endtask : t_reset

    task automatic t_knock();
        // Fields {single, double, sign, X, Y, Z}; every field toggles across the set
        logic [5:0] f[4] = '{6'b100100, 6'b010010, 6'b101001, 6'b011110};
        foreach (f[i]) begin
            @(posedge clk_i);
            knock_f <= f[i];
            ev(5'h01);
            rd_chk(IDX_KNOCK, {2'b01, f[i]});
        end
        rd_chk(IDX_KNOCK, 8'h00);
        $display("knock source done");
    endtask : t_knock

    task automatic t_orient();
        for (int i = 0; i < LIM_W; i++) begin
            @(posedge clk_i);
            orient_lim_i <= 6'(1 << i);
            ev(5'h02);
            rd_chk(IDX_ORIENT, {2'b01, 6'(1 << i)});
        end
        $display("orientation source done");
    endtask : t_orient

    task automatic t_samples();
        logic [15:0] w[4] = '{16'hf800, 16'h8001, 16'h1234, 16'hfedc};
        @(posedge clk_i);
        temp_raw_i <= 12'h800;
        {gx, gy, gz} <= {w[1], w[2], w[3]};
        ev(5'h1c);
        rd_chk(IDX_READY, 8'h07);
        for (int i = 0; i < 4; i++) begin
            rd_chk(8'(8'h20 + 2 * i), w[i][7:0]);
            rd_chk(8'(8'h21 + 2 * i), w[i][15:8]);
        end
        rd_chk(IDX_READY, 8'h00);
        @(posedge clk_i);
        temp_raw_i <= 12'h7ff;
        ev(5'h04);
        rd_chk(IDX_READY, 8'h04);
        rd_chk(IDX_TEMP_L, 8'hff);
        rd_chk(IDX_TEMP_H, 8'h07);
        $display("sample readout done");
    endtask : t_samples

    task automatic t_write_ignored();
        wr(IDX_RATE_Z_L, 8'h5a);
        rd_chk(IDX_RATE_Z_L, 8'hdc);
        wr(IDX_RATE_X_H, 8'h00);
        rd_chk(IDX_RATE_X_H, 8'h80);
        wr(IDX_READY, 8'hff);
        rd_chk(IDX_READY, 8'h00);
        rd_chk(8'h30, 8'h00);
        $display("write ignored done");
    endtask : t_write_ignored

    task automatic t_irq();
        logic [7:0] v;
        wr(IDX_IRQ_STATUS, 8'h1f);
        wr(IDX_IRQ_MASK, 8'h01);
        rd_chk(IDX_IRQ_MASK, 8'h01);
        // Write without the low byte select must leave the mask alone
        motion_host_model_i.cycle(1'b1, IDX_IRQ_MASK, 8'h00, 4'h0, v);
        rd_chk(IDX_IRQ_MASK, 8'h01);
        ev(5'h02);
        repeat (2) @(posedge clk_i);
        #1 chk({7'h00, irq_o}, 8'h00);
        ev(5'h01);
        repeat (2) @(posedge clk_i);
        #1 chk({7'h00, irq_o}, 8'h01);
        rd_chk(IDX_IRQ_STATUS, 8'h03);
        wr(IDX_IRQ_STATUS, 8'h01);
        @(posedge clk_i);
        #1 chk({7'h00, irq_o}, 8'h00);
        rd_chk(IDX_IRQ_STATUS, 8'h02);
        $display("interrupt done");
    endtask : t_irq

    // Main sequence: reset held 12 cycles, first request right after release
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_knock();
        t_orient();
        t_samples();
        t_write_ignored();
        t_irq();
        test_done();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #50us;
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        test_done();
    end
endmodule : testbench
